// ===== inc/pam_pkg.sv
// Constants, register map and state layout of the PCI/Add-On mailbox unit.
// How it works
// - An outgoing write also fills the far incoming box and sets both full flags.
// - Reading an incoming box clears its full flags in both status views.
// - PCI outgoing bytes 0 and 1 flag bits 12 and 13; flags follow byte strobes.
// - Each side's reset control register has a bit clearing every mailbox flag.
// - Writing one clears all flags at once; zero does nothing; status ignores writes.
// - Each side enables incoming-full and outgoing-empty interrupts on its own chosen byte.
// - Selected incoming byte full with enable raises that side's interrupt.
// - Selected outgoing byte emptied by the far side's read raises that side's interrupt.
// - External port line n loads Add-On outgoing mailbox bit 24 plus n.
// - Direction strap high means input only; low means bidirectional port.
// - Input mode: load low at an Add-On clock edge writes byte 3 like a bus write.
// - Add-On outgoing byte 3 keeps the most recent write from port or bus.
// - Bidirectional with load high: port drives PCI outgoing byte 3, updated on PCI writes.
// - Bidirectional with load low: port released so outside data can be loaded.
// - A turnaround cycle separates device drive from outside drive on the port.
// - No burst to mailbox registers; a burst ends with disconnect after current data.
// - Writes to full bytes overwrite; reads of empty bytes return stale contents.
// - PCI interrupt asserts on the edge after the completing Add-On write or read.
// - PCI interrupt drops one clock after software writes one to its source bit.
// - Add-On interrupt asserts on the edge after the completing PCI write or read.
// - Add-On interrupt drops one clock after a one is written to its source bit.
`default_nettype none
package pam_pkg;
  localparam logic [7:0] OFS_P_OUTBOX = 8'h00;
  localparam logic [7:0] OFS_P_INBOX = 8'h04;
  localparam logic [7:0] OFS_P_FLAGS = 8'h08;
  localparam logic [7:0] OFS_P_ICSR = 8'h0C;
  localparam logic [7:0] OFS_P_RESET = 8'h10;
  localparam logic [7:0] OFS_A_OUTBOX = 8'h40;
  localparam logic [7:0] OFS_A_INBOX = 8'h44;
  localparam logic [7:0] OFS_A_FLAGS = 8'h48;
  localparam logic [7:0] OFS_A_ICSR = 8'h4C;
  localparam logic [7:0] OFS_A_RESET = 8'h50;
  // Flag fields of the two status views.
  localparam int P_FLAG_IN_LSB = 28;
  localparam int P_FLAG_OUT_LSB = 12;
  localparam int A_FLAG_OUT_LSB = 28;
  localparam int A_FLAG_IN_LSB = 12;
  // PCI interrupt control/status fields.
  localparam int P_OSEL_LSB = 0;
  localparam int P_OEN_BIT = 4;
  localparam int P_ISEL_LSB = 8;
  localparam int P_IEN_BIT = 12;
  localparam int P_OINT_BIT = 16;
  localparam int P_IINT_BIT = 17;
  localparam int P_ASSERT_BIT = 23;
  // Add-On interrupt control/status fields.
  localparam int A_ISEL_LSB = 0;
  localparam int A_IEN_BIT = 4;
  localparam int A_OSEL_LSB = 8;
  localparam int A_OEN_BIT = 12;
  localparam int A_IINT_BIT = 16;
  localparam int A_OINT_BIT = 17;
  localparam int A_ASSERT_BIT = 23;
  localparam int FLAG_RESET_BIT = 0;
  localparam int BYTE3_LSB = 24;
  // Pin synchroniser vector layout.
  localparam int SY_PORT_LSB = 0;
  localparam int SY_STRAP_BIT = 8;
  localparam int SY_LOAD_BIT = 9;
  localparam int SY_CLK_BIT = 10;
  localparam logic [10:0] SYNC_RST = 11'h300;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [10:0] sync3;
    logic [10:0] filt;
    logic [31:0] p2a_box;
    logic [31:0] a2p_box;
    logic [3:0] p2a_full;
    logic [3:0] a2p_full;
    logic [1:0] p_osel;
    logic [1:0] p_isel;
    logic p_oen;
    logic p_ien;
    logic p_oint;
    logic p_iint;
    logic [1:0] a_osel;
    logic [1:0] a_isel;
    logic a_oen;
    logic a_ien;
    logic a_oint;
    logic a_iint;
    logic arm;
    logic drive;
    logic [31:0] rdata;
    logic slverr;
  } pam_state_s;
endpackage
`default_nettype wire

// ===== rtl/pam_mailbox.sv
// Mailbox pair with flags, interrupts and external byte port behind one APB slave.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`default_nettype none
module pam_mailbox
  import pam_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic addon_clk,
  input wire logic load_n,
  input wire logic byte_port_direction_strap,
  input wire logic [7:0] external_byte_port_in,
  output logic [7:0] external_byte_port_out,
  output logic external_byte_port_oe,
  output logic pci_int_n_out,
  output logic pci_int_n_oe,
  output logic addon_irq_n
);
  pam_state_s s_reg;
  pam_state_s s_next;

  always_comb begin
    logic acc;
    logic wr;
    logic rd;
    logic edge_seen;
    logic load_low;
    logic bidir;
    logic port_load;
    logic flag_clear;
    logic [3:0] a_strb;
    logic [31:0] word;
    logic p_in_ev;
    acc = psel & penable;
    wr = acc & pwrite;
    rd = acc & ~pwrite;
    edge_seen = 1'b0;
    load_low = 1'b0;
    bidir = 1'b0;
    port_load = 1'b0;
    flag_clear = 1'b0;
    a_strb = 4'h0;
    word = WORD_ZERO;
    p_in_ev = 1'b0;
    s_next = s_reg;

    // Three-stage pin capture; a bit moves only once stages two and three agree.
    s_next.sync1 = {addon_clk, load_n, byte_port_direction_strap, external_byte_port_in};
    s_next.sync2 = s_reg.sync1;
    s_next.sync3 = s_reg.sync2;
    for (int i = 0; i < 11; i++) begin
      if (s_reg.sync2[i] == s_reg.sync3[i]) begin
        s_next.filt[i] = s_reg.sync3[i];
      end
    end
    edge_seen = ~s_reg.filt[SY_CLK_BIT] & s_next.filt[SY_CLK_BIT];
    load_low = ~s_reg.filt[SY_LOAD_BIT];
    bidir = ~s_reg.filt[SY_STRAP_BIT];

    // Load is honoured in input mode, or in bidirectional mode once the drive is off.
    port_load = edge_seen & load_low & (~bidir | ~s_reg.drive);

    // The port drives only after two Add-On edges with load high: one is turnaround.
    s_next.arm = bidir & ~load_low & (s_reg.arm | edge_seen);
    s_next.drive = bidir & ~load_low & (s_reg.drive | (edge_seen & s_reg.arm));

    // Flag reset from either side; sets below are applied after it and win.
    if (wr && (paddr == OFS_P_RESET || paddr == OFS_A_RESET) && pstrb[0]) begin
      flag_clear = pwdata[FLAG_RESET_BIT];
    end
    if (flag_clear) begin
      s_next.p2a_full = 4'h0;
      s_next.a2p_full = 4'h0;
    end

    // Incoming reads: whole-word access empties every byte of the box.
    if (rd && paddr == OFS_A_INBOX) begin
      s_next.p2a_full = 4'h0;
      if (s_reg.p_oen && s_reg.p2a_full[s_reg.p_osel]) begin
        s_next.p_oint = 1'b1;
      end
    end
    if (rd && paddr == OFS_P_INBOX) begin
      s_next.a2p_full = 4'h0;
      if (s_reg.a_oen && s_reg.a2p_full[s_reg.a_osel]) begin
        s_next.a_oint = 1'b1;
      end
    end

    // Outgoing writes fill the shared box and set both views of the flags.
    if (wr && paddr == OFS_P_OUTBOX) begin
      for (int i = 0; i < 4; i++) begin
        if (pstrb[i]) begin
          s_next.p2a_box[i*8 +: 8] = pwdata[i*8 +: 8];
          s_next.p2a_full[i] = 1'b1;
        end
      end
      if (s_reg.a_ien && pstrb[s_reg.a_isel]) begin
        s_next.a_iint = 1'b1;
      end
    end
    if (wr && paddr == OFS_A_OUTBOX) begin
      a_strb = pstrb;
      for (int i = 0; i < 4; i++) begin
        if (pstrb[i]) begin
          s_next.a2p_box[i*8 +: 8] = pwdata[i*8 +: 8];
          s_next.a2p_full[i] = 1'b1;
        end
      end
    end
    // A port load in the same cycle as a bus write of byte 3 is taken as the later one.
    if (port_load) begin
      a_strb[3] = 1'b1;
      s_next.a2p_box[BYTE3_LSB +: 8] = s_reg.filt[SY_PORT_LSB +: 8];
      s_next.a2p_full[3] = 1'b1;
    end
    p_in_ev = s_reg.p_ien & a_strb[s_reg.p_isel];
    if (p_in_ev) begin
      s_next.p_iint = 1'b1;
    end

    // Interrupt control/status: one to a source bit clears it unless an event sets it.
    if (wr && paddr == OFS_P_ICSR) begin
      if (pstrb[0]) begin
        s_next.p_osel = pwdata[P_OSEL_LSB +: 2];
        s_next.p_oen = pwdata[P_OEN_BIT];
      end
      if (pstrb[1]) begin
        s_next.p_isel = pwdata[P_ISEL_LSB +: 2];
        s_next.p_ien = pwdata[P_IEN_BIT];
      end
      if (pstrb[2] && pwdata[P_OINT_BIT] && s_next.p_oint == s_reg.p_oint) begin
        s_next.p_oint = 1'b0;
      end
      // A port load in the clearing cycle keeps the source set when byte 3 is selected and enabled.
      if (pstrb[2] && pwdata[P_IINT_BIT] && !p_in_ev) begin
        s_next.p_iint = 1'b0;
      end
    end
    if (wr && paddr == OFS_A_ICSR) begin
      if (pstrb[0]) begin
        s_next.a_isel = pwdata[A_ISEL_LSB +: 2];
        s_next.a_ien = pwdata[A_IEN_BIT];
      end
      if (pstrb[1]) begin
        s_next.a_osel = pwdata[A_OSEL_LSB +: 2];
        s_next.a_oen = pwdata[A_OEN_BIT];
      end
      if (pstrb[2] && pwdata[A_IINT_BIT] && s_next.a_iint == s_reg.a_iint) begin
        s_next.a_iint = 1'b0;
      end
      if (pstrb[2] && pwdata[A_OINT_BIT] && s_next.a_oint == s_reg.a_oint) begin
        s_next.a_oint = 1'b0;
      end
    end

    // Read data is prepared in the setup cycle so that prdata comes from a flop.
    if (psel && !penable) begin
      s_next.slverr = 1'b0;
      case (paddr)
        OFS_P_OUTBOX: word = s_reg.p2a_box;
        OFS_P_INBOX: word = s_reg.a2p_box;
        OFS_P_FLAGS: begin
          word[P_FLAG_IN_LSB +: 4] = s_reg.a2p_full;
          word[P_FLAG_OUT_LSB +: 4] = s_reg.p2a_full;
        end
        OFS_P_ICSR: begin
          word[P_OSEL_LSB +: 2] = s_reg.p_osel;
          word[P_OEN_BIT] = s_reg.p_oen;
          word[P_ISEL_LSB +: 2] = s_reg.p_isel;
          word[P_IEN_BIT] = s_reg.p_ien;
          word[P_OINT_BIT] = s_reg.p_oint;
          word[P_IINT_BIT] = s_reg.p_iint;
          word[P_ASSERT_BIT] = s_reg.p_oint | s_reg.p_iint;
        end
        OFS_A_OUTBOX: word = s_reg.a2p_box;
        OFS_A_INBOX: word = s_reg.p2a_box;
        OFS_A_FLAGS: begin
          word[A_FLAG_OUT_LSB +: 4] = s_reg.a2p_full;
          word[A_FLAG_IN_LSB +: 4] = s_reg.p2a_full;
        end
        OFS_A_ICSR: begin
          word[A_ISEL_LSB +: 2] = s_reg.a_isel;
          word[A_IEN_BIT] = s_reg.a_ien;
          word[A_OSEL_LSB +: 2] = s_reg.a_osel;
          word[A_OEN_BIT] = s_reg.a_oen;
          word[A_IINT_BIT] = s_reg.a_iint;
          word[A_OINT_BIT] = s_reg.a_oint;
          word[A_ASSERT_BIT] = s_reg.a_oint | s_reg.a_iint;
        end
        OFS_P_RESET, OFS_A_RESET: word = WORD_ZERO;
        default: s_next.slverr = 1'b1;
      endcase
      s_next.rdata = word;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.sync1 <= SYNC_RST;
      s_reg.sync2 <= SYNC_RST;
      s_reg.sync3 <= SYNC_RST;
      s_reg.filt <= SYNC_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Every access is single-beat with no wait states, so a burst cannot form.
  assign pready = psel & penable;
  assign prdata = s_reg.rdata;
  assign pslverr = s_reg.slverr;
  assign external_byte_port_out = s_reg.p2a_box[BYTE3_LSB +: 8];
  assign external_byte_port_oe = s_reg.drive;
  assign pci_int_n_out = 1'b0;
  assign pci_int_n_oe = s_reg.p_oint | s_reg.p_iint;
  assign addon_irq_n = ~(s_reg.a_oint | s_reg.a_iint);
endmodule
`default_nettype wire

// ===== verif/pam_mailbox_chk.sv
// Port-level assertions for the mailbox unit.
`default_nettype none
module pam_mailbox_chk
  import pam_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic load_n,
  input wire logic byte_port_direction_strap,
  input wire logic [7:0] external_byte_port_out,
  input wire logic external_byte_port_oe,
  input wire logic pci_int_n_oe,
  input wire logic addon_irq_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable;
  wire pci_box = acc && (pwrite ? paddr == OFS_P_OUTBOX : paddr == OFS_P_INBOX);
  wire add_box = acc && (pwrite ? paddr == OFS_A_OUTBOX : paddr == OFS_A_INBOX);
  wire rst_wr = acc && pwrite && pstrb[0] && pwdata[FLAG_RESET_BIT];
  sequence s_flag_clear;
    rst_wr && (paddr == OFS_P_RESET || paddr == OFS_A_RESET);
  endsequence
  sequence s_flag_read;
    psel && !penable && !pwrite && paddr == OFS_P_FLAGS;
  endsequence
  a_flag_reset: assert property (s_flag_clear ##3 s_flag_read |=> prdata == WORD_ZERO)
    else $error("flags survive a flag reset");
  a_port_release: assert property ($fell(load_n) |-> ##[1:7] !external_byte_port_oe)
    else $error("port still driven during load");
  a_input_only: assert property (byte_port_direction_strap [*6] |-> !external_byte_port_oe)
    else $error("port driven in input mode");
  a_port_follow: assert property (acc && pwrite && paddr == OFS_P_OUTBOX && pstrb[3]
    |=> external_byte_port_out == $past(pwdata[31:24]))
    else $error("port does not follow byte 3");
  a_drive_turnaround: assert property ($rose(external_byte_port_oe)
    |-> $past(load_n, 4) && $past(load_n, 12))
    else $error("port driven without turnaround");
  a_pci_clear: assert property (acc && pwrite && paddr == OFS_P_ICSR && pstrb[2]
    && pwdata[17:16] == 2'b11 |-> ##1 !pci_int_n_oe)
    else $error("PCI interrupt not released");
  a_addon_clear: assert property (acc && pwrite && paddr == OFS_A_ICSR && pstrb[2]
    && pwdata[17:16] == 2'b11 |-> ##1 addon_irq_n)
    else $error("Add-On interrupt not released");
  a_addon_cause: assert property ($fell(addon_irq_n) |-> $past(pci_box) || $past(pci_box, 2))
    else $error("Add-On interrupt without PCI access");
  a_pci_cause: assert property ($rose(pci_int_n_oe) |-> $past(add_box) || $past(add_box, 2)
    || !$past(load_n, 4) || !$past(load_n, 6))
    else $error("PCI interrupt without Add-On access");
endmodule
bind pam_mailbox pam_mailbox_chk u_pam_mailbox_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .load_n(load_n),
  .byte_port_direction_strap(byte_port_direction_strap),
  .external_byte_port_out(external_byte_port_out),
  .external_byte_port_oe(external_byte_port_oe), .pci_int_n_oe(pci_int_n_oe),
  .addon_irq_n(addon_irq_n));
`default_nettype wire

// ===== verif/pam_ext_model.sv
// Outside port logic: Add-On clock source and the shared byte port wire.
`default_nettype none
module pam_ext_model (
  input wire logic run,
  input wire logic load_n,
  input wire logic [7:0] data,
  input wire logic [7:0] port_out,
  input wire logic port_oe,
  output logic addon_clk,
  output logic [7:0] port_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial addon_clk = 1'b0;
  // The clock stands still while run is low.
  always #62.5 addon_clk = run ? ~addon_clk : 1'b0;
  // Outside data goes on only once the device has let go; a floating port shows junk.
  assign port_in = port_oe ? port_out : (load_n ? ~port_out : data);
endmodule
`default_nettype wire

// ===== verif/pam_mailbox_bench.sv
// Self-checking bench of the mailbox unit.
`default_nettype none
module pam_mailbox_bench
  import pam_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic load_n = 1'b1, strap = 1'b1, run = 1'b0;
  logic [7:0] paddr = 8'h00, pdat = 8'h00, p_in, p_out;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, a_clk, p_oe, i_out, i_oe, irq_n;
  int n_errors = 0, total_checks = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  pam_mailbox u_pam_mailbox (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .addon_clk(a_clk),
    .load_n(load_n), .byte_port_direction_strap(strap), .external_byte_port_in(p_in),
    .external_byte_port_out(p_out), .external_byte_port_oe(p_oe), .pci_int_n_out(i_out),
    .pci_int_n_oe(i_oe), .addon_irq_n(irq_n));
  pam_ext_model u_pam_ext_model (.run(run), .load_n(load_n), .data(pdat),
    .port_out(p_out), .port_oe(p_oe), .addon_clk(a_clk), .port_in(p_in));
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    // The value is taken when check is called; only the comparison waits for mid-cycle.
    @(negedge sys_clk);
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; returns at the idle edge after the access.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    check(rd, e);
  endtask
  task automatic t_reset;
    rdchk(OFS_P_FLAGS, WORD_ZERO);
    rdchk(8'h20, WORD_ZERO);
    check(32'(pslverr), 32'h1);
    check(32'(irq_n), 32'h1);
    check(32'(i_out), 32'h0);
    check(32'(i_oe), 32'h0);
    check(32'(p_oe), 32'h0);
    check(32'(pready), 32'h0);
  endtask
  task automatic t_pci_to_addon;
    wr(OFS_A_ICSR, 32'h0000_0011, 4'h1);
    wr(OFS_P_OUTBOX, 32'h4433_2211, 4'h3);
    check(32'(irq_n), 32'h0);
    rdchk(OFS_P_FLAGS, 32'h0000_3000);
    rdchk(OFS_A_FLAGS, 32'h0000_3000);
    wr(OFS_P_OUTBOX, 32'h0000_0077, 4'h1);
    rdchk(OFS_A_INBOX, 32'h0000_2277);
    rdchk(OFS_P_FLAGS, WORD_ZERO);
    wr(OFS_A_ICSR, 32'h0003_0000, 4'h4);
    check(32'(irq_n), 32'h1);
  endtask
  task automatic t_addon_to_pci;
    wr(OFS_P_ICSR, 32'h0000_0011, 4'h1);
    wr(OFS_P_OUTBOX, 32'h0000_AA00, 4'h2);
    check(32'(i_oe), 32'h0);
    rdchk(OFS_A_INBOX, 32'h0000_AA77);
    check(32'(i_oe), 32'h1);
    rdchk(OFS_P_ICSR, 32'h0081_0011);
    wr(OFS_P_ICSR, 32'h0003_0000, 4'h4);
    check(32'(i_oe), 32'h0);
    wr(OFS_A_ICSR, 32'h0003_0000, 4'h4);
  endtask
  task automatic t_flag_reset;
    wr(OFS_A_OUTBOX, 32'h8877_6655, 4'hF);
    rdchk(OFS_P_FLAGS, 32'hF000_0000);
    wr(OFS_P_FLAGS, WORD_ZERO, 4'hF);
    wr(OFS_A_RESET, WORD_ZERO, 4'h1);
    rdchk(OFS_A_FLAGS, 32'hF000_0000);
    wr(OFS_P_RESET, 32'h0000_0001, 4'h1);
    rdchk(OFS_P_FLAGS, WORD_ZERO);
    wr(OFS_P_OUTBOX, 32'hC300_0000, 4'h8);
    wr(OFS_A_RESET, 32'h0000_0001, 4'h1);
    rdchk(OFS_A_FLAGS, WORD_ZERO);
  endtask
  // Each 40-cycle wait below covers pin filtering plus at least two Add-On clock periods.
  task automatic t_port_in;
    wr(OFS_P_ICSR, 32'h0000_1300, 4'h2);
    run <= 1'b1;
    pdat <= 8'h1E;
    load_n <= 1'b0;
    repeat (40) @(posedge sys_clk);
    load_n <= 1'b1;
    run <= 1'b0;
    repeat (8) @(posedge sys_clk);
    check(32'(i_oe), 32'h1);
    rdchk(OFS_P_INBOX, 32'h1E77_6655);
    wr(OFS_A_OUTBOX, 32'h3C00_0000, 4'h8);
    rdchk(OFS_P_INBOX, 32'h3C77_6655);
    wr(OFS_P_ICSR, 32'h0003_0000, 4'h4);
  endtask
  task automatic t_port_bidir;
    strap <= 1'b0;
    run <= 1'b1;
    repeat (40) @(posedge sys_clk);
    check(32'(p_oe), 32'h1);
    check(32'(p_out), 32'h0000_00C3);
    @(posedge sys_clk);
    pdat <= 8'h69;
    load_n <= 1'b0;
    repeat (40) @(posedge sys_clk);
    check(32'(p_oe), 32'h0);
    @(posedge sys_clk);
    load_n <= 1'b1;
    run <= 1'b0;
    rdchk(OFS_P_INBOX, 32'h6977_6655);
    check(32'(i_oe), 32'h1);
  endtask
  // A reset in mid-run drops interrupts and flags; the port stays released with no Add-On clock.
  task automatic t_mid_reset;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdchk(OFS_P_FLAGS, WORD_ZERO);
    check(32'(i_oe), 32'h0);
    check(32'(irq_n), 32'h1);
    repeat (8) @(posedge sys_clk);
    check(32'(p_oe), 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_pci_to_addon();
    t_addon_to_pci();
    t_flag_reset();
    t_port_in();
    t_port_bidir();
    t_mid_reset();
    stop_test();
  end
endmodule
`default_nettype wire
